// [qdac_params.svh]
// Constants for the quad DAC serial load link: widths, field positions, codes, offsets, timing.
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH

`define QDAC_WORD_W 16
`define QDAC_CODE_W 12
`define QDAC_NUM_CH 4
`define QDAC_ADDR_HI_BIT 15
`define QDAC_ADDR_LO_BIT 14
`define QDAC_DATA_MSB 11
`define QDAC_ZERO_CODE 12'h000
`define QDAC_MID_CODE 12'h800
`define QDAC_MID_BIT 11
`define QDAC_FULL_CODE 12'hfff
`define QDAC_WORD_RESET 16'h0000
`define QDAC_BIT_CNT_W 5
`define QDAC_BITS_PER_WORD 5'h10
`define QDAC_BIT_CNT_RESET 5'h00
`define QDAC_BIT_CNT_ONE 5'h01

`define QDAC_APB_ADDR_W 8
`define QDAC_REG_DATA 8'h00
`define QDAC_REG_CTRL 8'h04
`define QDAC_REG_STATUS 8'h08
`define QDAC_CTRL_CLEAR_BIT 0
`define QDAC_CTRL_LEVEL_BIT 1
`define QDAC_STATUS_BUSY_BIT 0
`define QDAC_RDATA_RESET 32'h00000000

`define QDAC_CLK_PERIOD_NS 10
`define QDAC_SCLK_HALF_NS 80
`define QDAC_HALF_CYCLES (((`QDAC_SCLK_HALF_NS) / (`QDAC_CLK_PERIOD_NS)) < 1 ? 1 : \
    ((`QDAC_SCLK_HALF_NS) / (`QDAC_CLK_PERIOD_NS)))
`define QDAC_DIV_W 8

`endif

// [qdac_pkg.sv]
// Types for the quad DAC serial load link: the code type for the front end, the state type for the controller.
`default_nettype none
package qdac_pkg;

    typedef logic [11:0] qdac_code_type;

    typedef enum logic [5:0] {
        QDAC_IDLE = 6'h01,
        QDAC_SELECT = 6'h02,
        QDAC_CLK_LOW = 6'h04,
        QDAC_CLK_HIGH = 6'h08,
        QDAC_DESELECT = 6'h10,
        QDAC_LOAD = 6'h20
    } qdac_host_state_type;

endpackage : qdac_pkg
`default_nettype wire

// [qdac_link_if.sv]
// Pin-level link between the serial controller and the quad DAC front end.
`timescale 1ns/10ps
`default_nettype none
interface qdac_link_if;
    logic sclk;
    logic cs_n;
    logic serial_data_in;
    logic load_strobe_n;
    logic clear_n;
    logic clear_level_select;

    modport device (
        input sclk,
        input cs_n,
        input serial_data_in,
        input load_strobe_n,
        input clear_n,
        input clear_level_select
    );

    modport host (
        output sclk,
        output cs_n,
        output serial_data_in,
        output load_strobe_n,
        output clear_n,
        output clear_level_select
    );
endinterface : qdac_link_if
`default_nettype wire

// [qdac_tick_gen.sv]
// Half-period tick generator that paces the serial clock made by the controller.
`timescale 1ns/10ps
`default_nettype none
`include "qdac_params.svh"
module qdac_tick_gen (
    input wire logic clk,
    input wire logic resetn,
    output logic tick
);
    logic [`QDAC_DIV_W-1:0] count;
    logic [`QDAC_DIV_W-1:0] next_count;
    logic next_tick;

    // Wrap at the half-period count, one-cycle tick at the wrap
    always_comb begin
        next_tick = 1'b0;
        next_count = count + `QDAC_DIV_W'(1);
        if (count == `QDAC_DIV_W'(`QDAC_HALF_CYCLES - 1)) begin
            next_count = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : qdac_tick_gen
`default_nettype wire

// [qdac_device.sv]
// Quad 12-bit DAC serial front end: input shift register, address decode, four data registers.
//
// Overview of operation
// - Select low, shift data on clock rise
// - Word: two address, two filler, twelve data
// - Host shifts sixteen bits before load strobe
// - Address picks one register; others untouched
// - Clock and select ORed into shift clock
// - Select rising with clock low shifts extra
// - Host ends word with clock held high
// - Host starts word without spurious combined edge
// - Clear forces all registers zero or midscale
// - Clear is asynchronous, ignores chip select
// - After clear, registers hold until load
// - Host never shifts while load held low
// - Codes are straight binary, span over 4096
// - Transfer on load falling edge, any select
// - Level select high midscale, low zero
// - Clear leaves shift register unchanged
//
// This end has no system clock: every flip-flop here runs on an edge of
// a link pin, as the real part does. The outputs are the held codes and the shift register.
`timescale 1ns/10ps
`default_nettype none
`include "qdac_params.svh"
module qdac_device
    import qdac_pkg::*;
(
    qdac_link_if.device link,
    output qdac_code_type dac_code_a,
    output qdac_code_type dac_code_b,
    output qdac_code_type dac_code_c,
    output qdac_code_type dac_code_d,
    output logic [`QDAC_WORD_W-1:0] shift_word
);

    ////////////////////////////////////////////////////////////////////////////
    // Combined shift clock

    // Clock and select meet in one OR gate, so either can make the edge
    logic shift_clk;
    assign shift_clk = link.sclk | link.cs_n;

    // A select rise while the clock is low is a real edge here; the host
    // avoids it at both ends of a word, this side does not filter it
    logic [`QDAC_WORD_W-1:0] next_shift_word;

    ////////////////////////////////////////////////////////////////////////////
    // Input shift register

    // New bit enters at the bottom; the oldest falls out of the top
    always_comb begin
        next_shift_word = {shift_word[`QDAC_WORD_W-2:0], link.serial_data_in};
    end

    // Not touched by clear, so a word shifted before a clear can be reloaded
    always_ff @(posedge shift_clk) begin
        shift_word <= next_shift_word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word fields

    // First bit in ends at the top: address, filler, then data MSB first
    logic [1:0] word_addr;
    qdac_code_type word_data;
    assign word_addr = {shift_word[`QDAC_ADDR_HI_BIT], shift_word[`QDAC_ADDR_LO_BIT]};
    assign word_data = shift_word[`QDAC_DATA_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    // Clear decode

    // Split clear by level so each flop gets a constant under async clear;
    // the level pin is never copied into a flop by the clear itself
    logic clear_zero_n;
    logic clear_mid_n;
    assign clear_zero_n = link.clear_n | link.clear_level_select;
    assign clear_mid_n = link.clear_n | ~link.clear_level_select;

    ////////////////////////////////////////////////////////////////////////////
    // Data registers, one per channel

    qdac_code_type code [`QDAC_NUM_CH];
    qdac_code_type next_code [`QDAC_NUM_CH];

    genvar ch;
    generate
        for (ch = 0; ch < `QDAC_NUM_CH; ch = ch + 1) begin : g_chan
            // Only the addressed channel takes the word; the rest keep theirs
            always_comb begin
                next_code[ch] = code[ch];
                if (word_addr == 2'(ch)) begin
                    next_code[ch] = word_data;
                end
            end

            // Load edge is the clock; clear overrides without any edge.
            // Between a clear and the next load the cleared value simply holds.
            always_ff @(negedge link.load_strobe_n or negedge clear_zero_n or negedge clear_mid_n) begin
                if (!clear_zero_n) begin
                    code[ch] <= `QDAC_ZERO_CODE;
                end else if (!clear_mid_n) begin
                    code[ch] <= `QDAC_MID_CODE;
                end else begin
                    code[ch] <= next_code[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Straight binary: the analog side scales code by span over 4096.
    // Limitation: the flow-through while load stays low is not modelled;
    // the host keeps the shift register still in that time anyway.
    assign dac_code_a = code[0];
    assign dac_code_b = code[1];
    assign dac_code_c = code[2];
    assign dac_code_d = code[3];

endmodule : qdac_device
`default_nettype wire

// [qdac_host.sv]
// Serial controller for the quad DAC: APB registers, word shifter, load and clear pins.
`timescale 1ns/10ps
`default_nettype none
`include "qdac_params.svh"
module qdac_host
    import qdac_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`QDAC_APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    qdac_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////////
    // Pacing and state

    logic tick;
    qdac_tick_gen u_tick (
        .clk(clk),
        .resetn(resetn),
        .tick(tick)
    );

    qdac_host_state_type state, next_state;
    logic [`QDAC_WORD_W-1:0] word, next_word;
    logic [`QDAC_BIT_CNT_W-1:0] bits, next_bits;
    logic start, next_start;
    logic sclk, next_sclk, cs_n, next_cs_n, sdo, next_sdo, ld_n, next_ld_n;
    logic clr_n, next_clr_n, lvl, next_lvl;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic access, wr, busy;

    assign busy = start | (state != QDAC_IDLE);
    assign access = psel & penable & ~pready;
    assign wr = psel & penable & pready & pwrite & ~pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    always_comb begin
        next_pready = access;
        next_pslverr = 1'b0;
        next_prdata = `QDAC_RDATA_RESET;
        if (access) begin
            case (paddr)
                `QDAC_REG_DATA: begin
                    next_prdata[`QDAC_WORD_W-1:0] = word;
                    next_pslverr = pwrite & busy; // refused while a word is in flight
                end
                `QDAC_REG_CTRL: begin
                    next_prdata[`QDAC_CTRL_CLEAR_BIT] = ~clr_n;
                    next_prdata[`QDAC_CTRL_LEVEL_BIT] = lvl;
                end
                `QDAC_REG_STATUS: begin
                    next_prdata[`QDAC_STATUS_BUSY_BIT] = busy;
                    next_pslverr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word sequencer

    // Idle with clock and select high so selecting makes no combined rise
    always_comb begin
        next_state = state;
        next_word = word;
        next_bits = bits;
        next_start = start;
        next_sclk = sclk;
        next_cs_n = cs_n;
        next_sdo = sdo;
        next_ld_n = ld_n;
        next_clr_n = clr_n;
        next_lvl = lvl;
        if (wr && paddr == `QDAC_REG_CTRL) begin
            // Limitation: change level and clear in separate writes, else the
            // device's decoded clears may glitch while both pins move
            next_clr_n = ~pwdata[`QDAC_CTRL_CLEAR_BIT];
            next_lvl = pwdata[`QDAC_CTRL_LEVEL_BIT];
        end
        if (wr && paddr == `QDAC_REG_DATA) begin
            next_word = pwdata[`QDAC_WORD_W-1:0];
            next_start = 1'b1;
        end
        if (tick) begin
            case (state)
                QDAC_IDLE: begin
                    if (start) begin
                        next_cs_n = 1'b0;
                        next_bits = `QDAC_BIT_CNT_RESET;
                        next_state = QDAC_SELECT;
                    end
                end
                QDAC_SELECT, QDAC_CLK_HIGH: begin
                    if (bits == `QDAC_BITS_PER_WORD) begin
                        next_cs_n = 1'b1;
                        next_state = QDAC_DESELECT;
                    end else begin
                        next_sclk = 1'b0;
                        next_sdo = word[`QDAC_WORD_W-1];
                        next_word = {word[`QDAC_WORD_W-2:0], word[`QDAC_WORD_W-1]};
                        next_state = QDAC_CLK_LOW;
                    end
                end
                QDAC_CLK_LOW: begin
                    next_sclk = 1'b1;
                    next_bits = bits + `QDAC_BIT_CNT_ONE;
                    next_state = QDAC_CLK_HIGH;
                end
                QDAC_DESELECT: begin
                    next_ld_n = 1'b0;
                    next_state = QDAC_LOAD;
                end
                QDAC_LOAD: begin
                    next_ld_n = 1'b1;
                    next_start = 1'b0;
                    next_state = QDAC_IDLE;
                end
                default: begin
                    next_state = QDAC_IDLE;
                end
            endcase
        end
    end

    // Registers; every pin driven from a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= QDAC_IDLE;
            word <= `QDAC_WORD_RESET;
            bits <= `QDAC_BIT_CNT_RESET;
            start <= 1'b0;
            sclk <= 1'b1;
            cs_n <= 1'b1;
            sdo <= 1'b0;
            ld_n <= 1'b1;
            clr_n <= 1'b1;
            lvl <= 1'b0;
            prdata <= `QDAC_RDATA_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state <= next_state;
            word <= next_word;
            bits <= next_bits;
            start <= next_start;
            sclk <= next_sclk;
            cs_n <= next_cs_n;
            sdo <= next_sdo;
            ld_n <= next_ld_n;
            clr_n <= next_clr_n;
            lvl <= next_lvl;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.serial_data_in = sdo;
    assign link.load_strobe_n = ld_n;
    assign link.clear_n = clr_n;
    assign link.clear_level_select = lvl;

endmodule : qdac_host
`default_nettype wire

// [qdac_link_checker.sv]
// Concurrent checks on the serial link between the controller and the DAC front end.
`timescale 1ns/10ps
`default_nettype none
module qdac_link_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    input wire logic clear_n,
    input wire logic clear_level_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Rising shift edges seen since select fell; sclk is slow, so clk sees every edge
    // Previous pin levels kept in flops, so the counter needs no sampled-value calls
    logic prev_sclk;
    logic prev_cs_n;
    logic [4:0] n_rise;
    logic [4:0] next_n_rise;
    always_comb begin
        next_n_rise = n_rise;
        if (!cs_n && sclk && !prev_sclk) next_n_rise = n_rise + 5'h01;
        if (!cs_n && prev_cs_n) next_n_rise = 5'h00;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            n_rise <= 5'h00;
            prev_sclk <= 1'b1;
            prev_cs_n <= 1'b1;
        end else begin
            n_rise <= next_n_rise;
            prev_sclk <= sclk;
            prev_cs_n <= cs_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link protocol: select edges make no combined shift rise, data stable, sixteen shifts per word, load and sclk low widths
    cs_fall_high_a: assert property ($fell(cs_n) |-> sclk)
        else $error("select fell while sclk low");
    cs_rise_high_a: assert property ($rose(cs_n) |-> sclk && $past(sclk))
        else $error("select rose while sclk low");
    sclk_selected_a: assert property ($fell(sclk) |-> !cs_n)
        else $error("sclk toggled while deselected");
    data_held_a: assert property ($rose(sclk) |-> $stable(serial_data_in))
        else $error("data changed on the shift edge");
    word_count_a: assert property ($rose(cs_n) |-> n_rise == 5'h10)
        else $error("word did not hold sixteen shifts");
    load_after_word_a: assert property ($fell(load_strobe_n) |-> cs_n && n_rise == 5'h10)
        else $error("load strobed before a full word");
    no_shift_load_a: assert property (!load_strobe_n |-> cs_n && sclk && $stable(sclk))
        else $error("shift activity while load low");
    load_pulse_a: assert property ($fell(load_strobe_n) |-> !load_strobe_n[*4] ##[1:12] load_strobe_n)
        else $error("load pulse width wrong");
    sclk_low_a: assert property ($fell(sclk) |-> !sclk[*4] ##[1:12] sclk)
        else $error("sclk low phase wrong");

    // Both clear levels should be exercised
    clear_mid_c: cover property ($fell(clear_n) && clear_level_select);
    clear_zero_c: cover property ($fell(clear_n) && !clear_level_select);
endmodule : qdac_link_checker
`default_nettype wire

// [tb_quad_dac_serial_load_clear.sv]
// Self-checking bench: APB controller driving the quad DAC front end over the link.
`timescale 1ns/10ps
`default_nettype none
`include "qdac_params.svh"
module tb_quad_dac_serial_load_clear
    import qdac_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    qdac_code_type dac_code_a, dac_code_b, dac_code_c, dac_code_d;
    logic [15:0] shift_word;
    qdac_code_type exp_code [4];
    qdac_code_type pat [4] = '{12'hfff, 12'h800, 12'h001, 12'h7fe};
    logic [15:0] word;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int n_tests = 0;

    // 100 MHz system clock
    always #5 clk = ~clk;

    qdac_link_if qdac_link_if_i ();
    qdac_host qdac_host_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(qdac_link_if_i.host));
    qdac_device qdac_device_i (.link(qdac_link_if_i.device), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
        .dac_code_c(dac_code_c), .dac_code_d(dac_code_d), .shift_word(shift_word));
    qdac_link_checker qdac_link_checker_i (.clk(clk), .resetn(resetn), .sclk(qdac_link_if_i.sclk),
        .cs_n(qdac_link_if_i.cs_n), .serial_data_in(qdac_link_if_i.serial_data_in),
        .load_strobe_n(qdac_link_if_i.load_strobe_n), .clear_n(qdac_link_if_i.clear_n),
        .clear_level_select(qdac_link_if_i.clear_level_select));

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] expect_v);
        n_tests++;
        if (seen !== expect_v) begin
            fails++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, expect_v);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls busy; a word takes about 300 clk, so 200 polls is ample
    task wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `QDAC_REG_STATUS, 32'h00000000);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        if (n >= 200) fails++;
    endtask : wait_idle

    task codes_chk();
        chk({20'h00000, dac_code_a}, {20'h00000, exp_code[0]});
        chk({20'h00000, dac_code_b}, {20'h00000, exp_code[1]});
        chk({20'h00000, dac_code_c}, {20'h00000, exp_code[2]});
        chk({20'h00000, dac_code_d}, {20'h00000, exp_code[3]});
    endtask : codes_chk

    task final_report();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        // Clear at both levels, then release: codes must stay put
        // Level is set before clear and kept past release, so the decoded clears never glitch
        for (int lv = 0; lv < 2; lv++) begin
            apb(1'b1, `QDAC_REG_CTRL, {30'h0, lv[0], 1'b0});
            apb(1'b1, `QDAC_REG_CTRL, {30'h0, lv[0], 1'b1});
            @(posedge clk);
            for (int ch = 0; ch < 4; ch++) exp_code[ch] = lv[0] ? `QDAC_MID_CODE : `QDAC_ZERO_CODE;
            codes_chk();
            apb(1'b1, `QDAC_REG_CTRL, {30'h0, lv[0], 1'b0});
            @(posedge clk);
            codes_chk();
        end
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000000);
        $display("test clear levels done");
        // Each address loads its own channel; a second word while busy is refused
        for (int ch = 0; ch < 4; ch++) begin
            word = {ch[1:0], 2'b10, pat[ch]};
            apb(1'b1, `QDAC_REG_DATA, {16'h0000, word});
            chk({31'h0, err}, 32'h0);
            apb(1'b1, `QDAC_REG_DATA, 32'h0000ffff);
            chk({31'h0, err}, 32'h1);
            wait_idle();
            exp_code[ch] = pat[ch];
            chk({16'h0000, shift_word}, {16'h0000, word});
            codes_chk();
        end
        $display("test address decode done");
        // Clear in the middle of a word, then the word still loads
        word = 16'h85a5;
        apb(1'b1, `QDAC_REG_DATA, {16'h0000, word});
        n = 0;
        while (qdac_link_if_i.cs_n !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) fails++;
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000001);
        @(posedge clk);
        chk({31'h0, qdac_link_if_i.cs_n}, 32'h0);
        for (int ch = 0; ch < 4; ch++) exp_code[ch] = `QDAC_ZERO_CODE;
        codes_chk();
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000000);
        wait_idle();
        exp_code[2] = 12'h5a5;
        codes_chk();
        // Clear must leave the shift register alone; level goes first
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000002);
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000003);
        @(posedge clk);
        chk({16'h0000, shift_word}, {16'h0000, word});
        for (int ch = 0; ch < 4; ch++) exp_code[ch] = `QDAC_MID_CODE;
        codes_chk();
        apb(1'b0, `QDAC_REG_CTRL, 32'h00000000);
        chk(rd, 32'h00000003);
        apb(1'b1, `QDAC_REG_CTRL, 32'h00000002);
        $display("test clear mid word done");
        // Read-only and unmapped places are refused
        apb(1'b1, `QDAC_REG_STATUS, 32'h00000001);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h0c, 32'h00000000);
        chk({31'h0, err}, 32'h1);
        chk(rd, `QDAC_RDATA_RESET);
        $display("test refusals done");
        final_report();
    end

    // Watchdog: the sequence needs well under 50k clk
    initial begin
        #500000;
        fails++;
        final_report();
    end
endmodule : tb_quad_dac_serial_load_clear
`default_nettype wire
